// File: hw/idv_top.sv
// integer-n feedback divider, phase-frequency comparator and lock indication
// assumes an ahb-lite master on hclk; rf and reference pins arrive asynchronously
//
// Overview of operation
// - feedback ratio equals four times main count plus swallow count.
// - main field holds count minus one; the divider loads it plus one.
// - main count is six binary bits, bit 0 least significant.
// - swallow count is two binary bits, 0 to 3, without offset.
// - every ratio from 12 to 259 is reachable.
// - main setting 1 with swallow 0 to 2 gives ratios 8, 9 and 10.
// - together the settings give 251 distinct ratios.
// - polarity select high swaps up and down actions.
// - lock indicator is pulsed, averaging low unlocked and high locked.
//
// Added by the designer: the AHB-Lite register port and the register offsets.
`timescale 1ns/100ps
module idv_top #(
    parameter logic [7:0] PHASE_WIN = idv_pkg::PHASE_WIN_DEF,
    parameter logic [7:0] LOCK_COUNT = idv_pkg::LOCK_COUNT_DEF
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // rf and reference pins
    input wire logic rf_input,
    input wire logic rf_input_comp,
    input wire logic ref_input,
    input wire logic comparison_clock_in_b,
    // loop outputs
    output logic up_pump_output,
    output logic down_pump_output,
    output logic lock_indicator,
    output logic irq
);
    import idv_pkg::*;

    // pin synchronisers
    logic [3:0] pin_s1_q;
    logic [3:0] pin_s2_q;
    logic rf_prev_q;
    logic ref_prev_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
        end else begin
            pin_s1_q <= {comparison_clock_in_b, ref_input, rf_input_comp, rf_input};
            pin_s2_q <= pin_s1_q;
        end
    end

    // differential levels and rising edges
    wire rf_level = pin_s2_q[0] & ~pin_s2_q[1];
    wire ref_level = pin_s2_q[2] & ~pin_s2_q[3];
    wire rf_rise = rf_level & ~rf_prev_q;
    wire ref_rise = ref_level & ~ref_prev_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rf_prev_q <= 1'b0;
            ref_prev_q <= 1'b0;
        end else begin
            rf_prev_q <= rf_level;
            ref_prev_q <= ref_level;
        end
    end

    // ahb address phase capture
    idv_ahb_req_t req_q;
    idv_ahb_req_t req_d;
    wire addr_take = hsel & htrans[1] & hready;
    wire [ADDR_W-1:0] a_off = haddr[ADDR_W-1:0];

    assign req_d.valid = addr_take;
    assign req_d.write = hwrite;
    assign req_d.addr = a_off;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_q <= '0;
        end else begin
            req_q <= req_d;
        end
    end

    // write decode in the data phase
    wire wr_go = req_q.valid & req_q.write;
    wire wr_ctrl = wr_go & (req_q.addr == ADDR_CTRL);
    wire wr_stat = wr_go & (req_q.addr == ADDR_IRQ_STAT);
    wire wr_mask = wr_go & (req_q.addr == ADDR_IRQ_MASK);

    // control register
    idv_ctrl_t ctrl_q;
    idv_ctrl_t ctrl_d;
    assign ctrl_d = wr_ctrl ? idv_ctrl_t'(hwdata[CTRL_W-1:0]) : ctrl_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= CTRL_RST;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // ratio decode
    wire cfg_ok = ratio_ok(ctrl_q.main_count_bits, ctrl_q.swallow_count_bits);
    wire [RATIO_W-1:0] ratio_now = ratio_of(ctrl_q.main_count_bits, ctrl_q.swallow_count_bits);
    wire run = ctrl_q.enable & cfg_ok;

    // feedback divider
    logic fb_edge;

    idv_modulus_divider #(
        .MAIN_W(MAIN_W),
        .SWAL_W(SWAL_W)
    ) u_div (
        .hclk(hclk),
        .hresetn(hresetn),
        .run(run),
        .rf_edge(rf_rise),
        .main_set(ctrl_q.main_count_bits),
        .swal_set(ctrl_q.swallow_count_bits),
        .fb_edge(fb_edge)
    );

    // phase-frequency comparator
    logic up_q;
    logic dn_q;
    wire ref_e = ref_rise & run;
    wire fb_e = fb_edge & run;
    wire up_n = up_q | ref_e;
    wire dn_n = dn_q | fb_e;
    wire both_n = up_n & dn_n;
    wire up_d = up_n & ~both_n;
    wire dn_d = dn_n & ~both_n;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            up_q <= 1'b0;
            dn_q <= 1'b0;
        end else if (!run) begin
            up_q <= 1'b0;
            dn_q <= 1'b0;
        end else begin
            up_q <= up_d;
            dn_q <= dn_d;
        end
    end

    // polarity swap of the pump outputs
    wire pol = ctrl_q.polarity_select;
    wire up_out_d = run & (pol ? dn_d : up_d);
    wire dn_out_d = run & (pol ? up_d : dn_d);

    logic up_out_q;
    logic dn_out_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            up_out_q <= 1'b0;
            dn_out_q <= 1'b0;
        end else begin
            up_out_q <= up_out_d;
            dn_out_q <= dn_out_d;
        end
    end

    // phase error width of each comparison
    logic [7:0] width_q;
    wire pump_active = up_q | dn_q;
    wire close_active = pump_active & ~(up_d | dn_d);
    wire close_aligned = ~pump_active & ref_e & fb_e;
    wire cmp_done = run & (close_active | close_aligned);
    wire cmp_good = close_aligned | (width_q < PHASE_WIN);
    wire [7:0] width_d = ~pump_active ? 8'h00 : (width_q == 8'hff) ? width_q : width_q + 8'h01;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            width_q <= '0;
        end else begin
            width_q <= width_d;
        end
    end

    // lock detector
    idv_lock_state_t lk_q;
    idv_lock_state_t lk_d;
    logic [7:0] good_q;
    logic [7:0] good_d;
    wire good_last = (good_q >= LOCK_COUNT - 8'h01);

    always_comb begin
        lk_d = lk_q;
        good_d = good_q;
        case (lk_q)
            LK_IDLE: begin
                if (cmp_done && cmp_good) begin
                    lk_d = LK_ACQ;
                    good_d = 8'h01;
                end
            end
            LK_ACQ: begin
                if (cmp_done && !cmp_good) begin
                    lk_d = LK_IDLE;
                    good_d = 8'h00;
                end else if (cmp_done && good_last) begin
                    lk_d = LK_LOCK;
                end else if (cmp_done) begin
                    good_d = good_q + 8'h01;
                end
            end
            LK_LOCK: begin
                if (cmp_done && !cmp_good) begin
                    lk_d = LK_IDLE;
                    good_d = 8'h00;
                end
            end
            default: begin
                lk_d = LK_IDLE;
                good_d = 8'h00;
            end
        endcase
        if (!run) begin
            lk_d = LK_IDLE;
            good_d = 8'h00;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lk_q <= LK_IDLE;
            good_q <= '0;
        end else begin
            lk_q <= lk_d;
            good_q <= good_d;
        end
    end

    // pulsed lock indication: drops in the cycle after each pump pulse cycle
    wire locked = (lk_q == LK_LOCK);
    logic lock_ind_q;
    wire lock_ind_d = locked & ~pump_active;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lock_ind_q <= 1'b0;
        end else begin
            lock_ind_q <= lock_ind_d;
        end
    end

    // events
    logic bad_prev_q;
    wire cfg_bad = ~cfg_ok;
    wire ev_gain = (lk_d == LK_LOCK) & ~locked;
    wire ev_lost = locked & (lk_d != LK_LOCK);
    wire ev_bad = cfg_bad & ~bad_prev_q;
    wire [IRQ_W-1:0] ev_vec = {ev_bad, ev_lost, ev_gain};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bad_prev_q <= 1'b0;
        end else begin
            bad_prev_q <= cfg_bad;
        end
    end

    // sticky interrupt status, set wins over write-one clear
    logic [IRQ_W-1:0] irq_stat_q;
    logic [IRQ_W-1:0] irq_mask_q;
    wire [IRQ_W-1:0] clr_vec = wr_stat ? hwdata[IRQ_W-1:0] : '0;
    wire [IRQ_W-1:0] irq_stat_d = (irq_stat_q & ~clr_vec) | ev_vec;
    wire [IRQ_W-1:0] irq_mask_d = wr_mask ? hwdata[IRQ_W-1:0] : irq_mask_q;
    logic irq_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat_q <= '0;
            irq_mask_q <= '0;
            irq_q <= 1'b0;
        end else begin
            irq_stat_q <= irq_stat_d;
            irq_mask_q <= irq_mask_d;
            irq_q <= |(irq_stat_d & irq_mask_d);
        end
    end

    // read data, prepared in the address phase
    logic [31:0] status_word;
    always_comb begin
        status_word = '0;
        status_word[ST_LOCKED] = locked;
        status_word[ST_UP] = up_out_q;
        status_word[ST_DOWN] = dn_out_q;
        status_word[ST_BAD_CFG] = cfg_bad;
        status_word[ST_RATIO_LSB +: RATIO_W] = ratio_now;
    end

    wire rd_take = addr_take & ~hwrite;
    wire [31:0] rd_ctrl = {{(32-CTRL_W){1'b0}}, ctrl_d};
    wire [31:0] rd_stat = {{(32-IRQ_W){1'b0}}, irq_stat_d};
    wire [31:0] rd_mask = {{(32-IRQ_W){1'b0}}, irq_mask_d};
    wire [31:0] rd_mux = (a_off == ADDR_CTRL) ? rd_ctrl :
                         (a_off == ADDR_STATUS) ? status_word :
                         (a_off == ADDR_IRQ_STAT) ? rd_stat :
                         (a_off == ADDR_IRQ_MASK) ? rd_mask : 32'h0000_0000;
    wire [31:0] rd_d = (rd_take && haddr[31:ADDR_W] == '0) ? rd_mux : 32'h0000_0000;

    logic [31:0] hrdata_q;
    logic hreadyout_q;
    logic hresp_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= '0;
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
        end else begin
            hrdata_q <= rd_d;
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
        end
    end

    // outputs
    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = hresp_q;
    assign up_pump_output = up_out_q;
    assign down_pump_output = dn_out_q;
    assign lock_indicator = lock_ind_q;
    assign irq = irq_q;

endmodule // idv_top

// File: hw/idv_pkg.sv
// shared constants, field layouts and helpers of the integer-n divider and comparator
// assumes one 200 mhz bus clock and an ahb-lite register port
package idv_pkg;

    // divider field widths
    localparam int MAIN_W = 6;
    localparam int SWAL_W = 2;
    localparam int RATIO_W = 9;
    localparam int PRE_W = 3;

    // prescaler moduli
    localparam logic [PRE_W-1:0] PRESCALE = 3'h4;
    localparam logic [PRE_W-1:0] PRESCALE_SWAL = 3'h5;

    // supported main settings (count minus one)
    localparam logic [MAIN_W-1:0] MAIN_SET_CONT_MIN = 6'h02;
    localparam logic [MAIN_W-1:0] MAIN_SET_ISO = 6'h01;
    localparam logic [SWAL_W-1:0] SWAL_ISO_MAX = 2'h2;

    // register byte offsets
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 4'h8;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 4'hc;

    // control register layout, low bits of the word
    typedef struct packed {
        logic enable;
        logic polarity_select;
        logic [SWAL_W-1:0] swallow_count_bits;
        logic [MAIN_W-1:0] main_count_bits;
    } idv_ctrl_t;
    localparam int CTRL_W = $bits(idv_ctrl_t);
    localparam idv_ctrl_t CTRL_RST = '{enable: 1'b0, polarity_select: 1'b0,
                                       swallow_count_bits: 2'h0, main_count_bits: 6'h02};

    // status register field positions
    localparam int ST_LOCKED = 0;
    localparam int ST_UP = 1;
    localparam int ST_DOWN = 2;
    localparam int ST_BAD_CFG = 3;
    localparam int ST_RATIO_LSB = 8;

    // interrupt status and mask layout
    localparam int IRQ_W = 3;
    localparam int IRQ_LOCK_GAIN = 0;
    localparam int IRQ_LOCK_LOST = 1;
    localparam int IRQ_BAD_CFG = 2;

    // lock detection defaults
    localparam logic [7:0] PHASE_WIN_DEF = 8'h02;
    localparam logic [7:0] LOCK_COUNT_DEF = 8'h10;

    typedef enum logic [1:0] {
        LK_IDLE = 2'b00,
        LK_ACQ = 2'b01,
        LK_LOCK = 2'b11
    } idv_lock_state_t;

    // captured ahb address phase
    typedef struct packed {
        logic valid;
        logic write;
        logic [ADDR_W-1:0] addr;
    } idv_ahb_req_t;

    // achieved ratio: four times the main count plus swallow
    function automatic logic [RATIO_W-1:0] ratio_of(input logic [MAIN_W-1:0] m, input logic [SWAL_W-1:0] s);
        logic [RATIO_W-1:0] n;
        n = RATIO_W'(m) + RATIO_W'(1);
        ratio_of = RATIO_W'({n, 2'b00}) + RATIO_W'(s);
    endfunction

    // continuous range plus the three isolated settings
    function automatic logic ratio_ok(input logic [MAIN_W-1:0] m, input logic [SWAL_W-1:0] s);
        ratio_ok = (m >= MAIN_SET_CONT_MIN) || ((m == MAIN_SET_ISO) && (s <= SWAL_ISO_MAX));
    endfunction

endpackage

// File: hw/idv_modulus_divider.sv
// dual-modulus prescaler with main and swallow counters
// assumes rf_edge is a one-cycle pulse per synchronised rf rising edge
`timescale 1ns/100ps
module idv_modulus_divider #(
    parameter int MAIN_W = 6,
    parameter int SWAL_W = 2
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // control
    input wire logic run,
    input wire logic rf_edge,
    input wire logic [MAIN_W-1:0] main_set,
    input wire logic [SWAL_W-1:0] swal_set,
    // divided output, one pulse per output cycle
    output logic fb_edge
);
    import idv_pkg::*;

    logic [PRE_W-1:0] pre_q;
    logic [MAIN_W:0] main_left_q;
    logic [SWAL_W-1:0] swal_left_q;
    logic fb_q;

    wire [MAIN_W:0] main_load = (MAIN_W+1)'(main_set) + (MAIN_W+1)'(1);
    wire [PRE_W-1:0] modulus = (swal_left_q != '0) ? PRESCALE_SWAL : PRESCALE;
    wire period_end = rf_edge && (pre_q == modulus - PRE_W'(1));
    wire last_period = (main_left_q == (MAIN_W+1)'(1));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_q <= '0;
            main_left_q <= '0;
            swal_left_q <= '0;
            fb_q <= 1'b0;
        end else if (!run) begin
            pre_q <= '0;
            main_left_q <= main_load;
            swal_left_q <= swal_set;
            fb_q <= 1'b0;
        end else begin
            fb_q <= rf_edge && period_end && last_period;
            if (period_end) begin
                pre_q <= '0;
                if (last_period) begin
                    main_left_q <= main_load;
                    swal_left_q <= swal_set;
                end else begin
                    main_left_q <= main_left_q - (MAIN_W+1)'(1);
                    swal_left_q <= (swal_left_q != '0) ? swal_left_q - SWAL_W'(1) : swal_left_q;
                end
            end else if (rf_edge) begin
                pre_q <= pre_q + PRE_W'(1);
            end
        end
    end

    assign fb_edge = fb_q;

endmodule // idv_modulus_divider

// File: verification/idv_top_assertions.sv
// port checks of the divider and comparator top
// assumes one hclk domain and a zero-wait ahb-lite master
`timescale 1ns/100ps
module idv_top_assertions (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // loop outputs
    input wire logic up_pump_output,
    input wire logic down_pump_output,
    input wire logic lock_indicator
);
    import idv_pkg::*;
    logic rd_q;
    logic wr_q;
    logic hi_q;
    logic [3:0] a_q;
    logic [9:0] ctl_q;
    logic [9:0] ctl_rd_q;
    wire take = hsel && htrans[1] && hready;
    wire st = rd_q && !hi_q && a_q == 4'h4;
    wire bad = !(ctl_q[5:0] >= 6'h02 || (ctl_q[5:0] == 6'h01 && ctl_q[7:6] <= 2'h2));
    // status is built from the control word as it stood in the address phase
    wire bad_rd = !(ctl_rd_q[5:0] >= 6'h02 || (ctl_rd_q[5:0] == 6'h01 && ctl_rd_q[7:6] <= 2'h2));
    wire [8:0] ratio = (9'(ctl_rd_q[5:0]) + 9'h001) * 9'h004 + 9'(ctl_rd_q[7:6]);
    wire pump = up_pump_output || down_pump_output;
    // shadow of the control word, updated at the end of a write data phase; writes decode the low offset only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            hi_q <= 1'b0;
            a_q <= 4'h0;
            ctl_q <= 10'h002;
            ctl_rd_q <= 10'h002;
        end else begin
            rd_q <= take && !hwrite;
            wr_q <= take && hwrite;
            if (take) begin
                hi_q <= haddr[31:4] != 28'h0;
                a_q <= haddr[3:0];
                ctl_rd_q <= ctl_q;
            end
            if (wr_q && a_q == 4'h0) begin
                ctl_q <= hwdata[9:0];
            end
        end
    end
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    bus_okay_a: assert property (hreadyout && !hresp) else $error("bus not ready or okay");
    idle_zero_a: assert property (!rd_q |-> hrdata == 32'h0) else $error("hrdata not zero");
    unmapped_zero_a: assert property (rd_q && hi_q |-> hrdata == 32'h0) else $error("unmapped read not zero");
    ctrl_back_a: assert property (rd_q && !hi_q && a_q == 4'h0 |-> hrdata == {22'h0, ctl_q})
        else $error("ctrl readback wrong");
    ratio_field_a: assert property (st |-> hrdata[16:8] == ratio)
        else $error("ratio field wrong");
    bad_flag_a: assert property (st |-> hrdata[3] == bad_rd)
        else $error("setting flag wrong");
    pump_excl_a: assert property (!(up_pump_output && down_pump_output))
        else $error("both pumps high");
    lock_drop_a: assert property (pump |-> ##[0:1] !lock_indicator)
        else $error("lock high over pump");
    refused_idle_a: assert property ((!ctl_q[9] || bad) [*6] |-> !(pump || lock_indicator))
        else $error("outputs active while refused");
    cover property (st && !bad);
    cover property (lock_indicator);
    cover property (down_pump_output);
endmodule // idv_top_assertions
bind idv_top idv_top_assertions chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .up_pump_output(up_pump_output),
    .down_pump_output(down_pump_output), .lock_indicator(lock_indicator));

// File: verification/idv_loop_partner.sv
// loop partner: rf source and a reference divided from it with a chosen phase
// assumes hclk; rf half period two cycles, rf stands still while idle
`timescale 1ns/100ps
module idv_loop_partner (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bench settings
    input wire logic run,
    input wire logic [8:0] div,
    input wire logic [8:0] ofs,
    // pins
    output logic rf_input,
    output logic rf_input_comp,
    output logic ref_input,
    output logic comparison_clock_in_b
);
    int cnt;
    int tick;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick <= 0;
            cnt <= 0;
            rf_input <= 1'b0;
        end else if (run && tick == 1) begin
            tick <= 0;
            rf_input <= !rf_input;
            cnt <= rf_input ? cnt : (cnt + 1) % div;
        end else if (run) begin
            tick <= tick + 1;
        end
    end
    assign rf_input_comp = !rf_input;
    assign ref_input = run && ((cnt + div - ofs) % div) < div / 2;
    assign comparison_clock_in_b = !ref_input;
endmodule // idv_loop_partner

// File: verification/idv_top_tb.sv
// bench: ahb master, integer model of the map and a lock search
// assumes the loop partner on the pins and a 200 mhz hclk
`timescale 1ns/100ps
module idv_top_tb;
    import idv_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic run = 1'b0;
    logic [8:0] div = 9'h009;
    logic [8:0] ofs = 9'h000;
    wire [31:0] hrdata;
    wire hreadyout, hresp, rf_p, rf_c, ref_p, ref_c, up, dn, lk, irq;
    logic [31:0] r;
    logic [31:0] d;
    logic [31:0] rst_v[4] = '{32'h002, 32'hc00, 32'h0, 32'h0};
    bit seen[int];
    int n_mismatch = 0;
    int n_compared = 0;
    int seed = 6;
    int hi, nu, nd, ms, ss, n;
    bit got;
    int nt[2] = '{9, 13};
    idv_top #(.LOCK_COUNT(8'h04)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rf_input(rf_p), .rf_input_comp(rf_c),
        .ref_input(ref_p), .comparison_clock_in_b(ref_c), .up_pump_output(up),
        .down_pump_output(dn), .lock_indicator(lk), .irq(irq));
    idv_loop_partner part_u (.hclk(hclk), .hresetn(hresetn), .run(run), .div(div), .ofs(ofs),
        .rf_input(rf_p), .rf_input_comp(rf_c), .ref_input(ref_p), .comparison_clock_in_b(ref_c));
    initial begin
        forever #2.5 hclk = ~hclk;
    end
    task automatic end_of_test;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen_v, input logic [31:0] exp_v, input string what);
        n_compared++;
        if (seen_v !== exp_v) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", what, exp_v, seen_v);
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        r = hrdata;
    endtask
    task automatic meas(input int cyc);
        hi = 0;
        nu = 0;
        nd = 0;
        repeat (cyc) begin
            @(posedge hclk);
            hi += int'(lk);
            nu += int'(up);
            nd += int'(dn);
        end
    endtask
    initial begin
        #400000;
        n_mismatch++;
        end_of_test();
    end
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, 32'(i * 4), 32'h0);
            chk(r, rst_v[i], "reset value");
        end
        d = $random(seed);
        bus(1'b1, d & 32'hfffffff0 | 32'h14, d);
        bus(1'b0, d & 32'hfffffff0 | 32'h14, 32'h0);
        chk(r, 32'h0, "unmapped");
        for (int i = 0; i < 256; i++) begin
            d = $random(seed) & 32'hfffffc00 | 32'(i);
            ms = i % 64;
            ss = i / 64;
            bus(1'b1, 32'h0, d);
            bus(1'b0, 32'h0, 32'h0);
            chk(r, 32'(i), "ctrl");
            bus(1'b0, 32'h4, 32'h0);
            chk(32'(r[16:8]), 32'(4 * (ms + 1) + ss), "ratio");
            got = (ms >= 2) || (ms == 1 && ss <= 2);
            chk(32'(r[3]), 32'(!got), "bad setting");
            if (r[3] === 1'b0) seen[int'(r[16:8])] = 1'b1;
        end
        chk(32'(seen.num()), 32'd251, "distinct ratios");
        chk(32'(irq), 32'h0, "irq masked");
        bus(1'b0, 32'h8, 32'h0);
        chk(r, 32'h4, "bad event");
        bus(1'b1, 32'hc, 32'h4);
        repeat (2) @(posedge hclk);
        chk(32'(irq), 32'h1, "irq raised");
        bus(1'b1, 32'h8, 32'h4);
        repeat (2) @(posedge hclk);
        chk(32'(irq), 32'h0, "irq cleared");
        bus(1'b1, 32'hc, 32'h3);
        run <= 1'b1;
        foreach (nt[j]) begin
            n = nt[j];
            div <= 9'(n);
            bus(1'b1, 32'h0, 32'h200 | 32'((n % 4) << 6) | 32'(n / 4 - 1));
            got = 1'b0;
            for (int k = 0; k < n && !got; k++) begin
                ofs <= 9'(k);
                repeat (800) @(posedge hclk);
                meas(200);
                got = hi > 100;
            end
            chk(32'(got), 32'h1, "lock found");
            bus(1'b0, 32'h4, 32'h0);
            chk(32'(r[0]), 32'h1, "locked flag");
        end
        chk(32'(irq), 32'h1, "lock irq");
        ofs <= 9'((int'(ofs) + 6) % n);
        repeat (800) @(posedge hclk);
        meas(200);
        chk(32'(hi < 100), 32'h1, "unlocked average");
        bus(1'b0, 32'h8, 32'h0);
        chk(r & 32'h3, 32'h3, "lock events");
        div <= 9'(n - 1);
        repeat (800) @(posedge hclk);
        meas(600);
        chk(32'(nu > nd), 32'h1, "fast ref up");
        bus(1'b1, 32'h0, 32'h342);
        meas(600);
        chk(32'(nd > nu), 32'h1, "inverted down");
        bus(1'b1, 32'h0, 32'h042);
        repeat (8) @(posedge hclk);
        meas(100);
        chk(32'(nu + nd + hi), 32'h0, "disabled idle");
        end_of_test();
    end
endmodule // idv_top_tb
